// ---- audio_serial_master_port.sv ----
// What this block does
// RULE_01: LSB framing sends 16 and 32 bit full frames like MSB framing.
// RULE_02: 24-bit LSB samples use two data accesses; one read per full event.
// RULE_03: 16-in-32 LSB needs one access; hardware forces other half to zero.
// RULE_04: LSB 16-in-32 sends zeros first; flags follow the real half-word.
// RULE_05: PCM ignores channel side; sync length selects short or long.
// RULE_06: PCM long sync holds word select 13 bits; short holds one bit.
// RULE_07: Software sets sample and channel width in PCM to space syncs.
// RULE_08: Bit rate is channel bits times two times sample rate.
// RULE_09: Divider clock is the system clock that also runs the bus.
// RULE_10: With master clock out, Fs is clk over 32or64*(2div+odd)*8or4.
// RULE_11: Without master clock out, Fs is clk over 32or64*(2div+odd).
// RULE_12: Master drives bit clock and word select; master clock only if enabled.
// RULE_13: Software programs divider, polarity, format, role, then enable last.
// RULE_14: First half-word is left; buffer-to-shifter sets empty and side.
// RULE_15: Frames are always left then right, never left alone.
// RULE_16: Half-word loads into 16-bit shifter at first bit, MSB first.
// RULE_17: Software writes next word before current transmission ends.
// RULE_18: Software waits for empty and busy both zero before disabling; the testbench waits for empty set and busy clear.
// RULE_19: Receive in 16-bit packets; full sets flag; data read clears it.
// RULE_20: Receive channel side follows the word select the block drives.
// RULE_21: New data over an unread word sets overrun, interrupts if enabled.
// RULE_22: Disabling during the last reception completes the current word.
// RULE_23: Master clock output runs at 256 times the sample rate.
// RULE_24: Data and word select change on falling edge; sampled on rising.
// RULE_25: Reset clears flags, shifter and buffers; clock and select idle; the code resets tx_empty_flag to 1.
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
module audio_serial_master_port
	import audio_serial_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	output logic bit_clock_out,
	output logic word_select_out,
	output logic serial_data_out,
	output logic serial_data_oe,
	input wire logic serial_data_in,
	output logic master_clock_out,
	output logic irq_out,
	output logic tx_dma_req,
	output logic rx_dma_req
);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [15:0] audio_config_reg;
	logic [15:0] audio_prescaler_reg;
	logic [15:0] tx_buf_reg;
	logic [15:0] rx_buf_reg;
	logic [15:0] shift_reg;
	logic tx_empty_flag;
	logic rx_full_flag;
	logic channel_side_flag;
	logic overrun_flag;
	logic busy_flag;
	logic sd_in_meta_reg;
	logic sd_in_reg;

	wire logic channel_width_sel = audio_config_reg[CFG_CHANNEL_WIDTH_SEL_BIT];
	wire logic [1:0] sample_width_sel = audio_config_reg[CFG_SAMPLE_WIDTH_SEL_LSB +: 2];
	wire logic serial_clock_idle_level = audio_config_reg[CFG_SERIAL_CLOCK_IDLE_LEVEL_BIT];
	wire logic [1:0] audio_standard_sel = audio_config_reg[CFG_STD_LSB +: 2];
	wire logic frame_sync_length_sel = audio_config_reg[CFG_FRAME_SYNC_LENGTH_SEL_BIT];
	wire logic rx_mode = audio_config_reg[CFG_DIR_RX_BIT];
	wire logic audio_port_enable = audio_config_reg[CFG_EN_BIT];
	wire logic audio_mode_select = audio_config_reg[CFG_MODE_BIT];
	wire logic tx_empty_irq_enable = audio_config_reg[CFG_TX_EMPTY_IRQ_ENABLE_BIT];
	wire logic rx_full_irq_enable = audio_config_reg[CFG_RX_FULL_IRQ_ENABLE_BIT];
	wire logic error_irq_enable = audio_config_reg[CFG_ERROR_IRQ_ENABLE_BIT];
	wire logic [7:0] clock_divider_value = audio_prescaler_reg[7:0];
	wire logic odd_bit = audio_prescaler_reg[PR_ODD_BIT];
	wire logic master_clock_out_enable = audio_prescaler_reg[PR_MASTER_CLOCK_OUT_ENABLE_BIT];

	// ------------------------------------------------------------
	// Clock generator
	// ------------------------------------------------------------
	// The kernel clock is clk itself, so no crossing is needed. [RULE_09]
	// Each divider output period lasts (2*div+odd) clk cycles, or 2 clk cycles for div below 2; odd
	// values give a duty cycle that differs by one clk cycle.
	logic [8:0] div_cnt_reg;
	logic [3:0] mck_cnt_reg;
	logic run_reg;
	logic bit_phase_reg;
	logic [4:0] bit_cnt_reg;
	logic [1:0] half_cnt_reg;
	logic [8:0] half_period;
	logic div_wrap;
	logic div_tick;
	logic bit_tick;
	logic [3:0] mck_ratio;
	logic frame32;
	logic sync_word;

	assign frame32 = channel_width_sel;
	assign half_period = (clock_divider_value < 8'h02) ? 9'h002
		: {clock_divider_value, 1'b0} + {8'h00, odd_bit};
	assign div_wrap = (div_cnt_reg == half_period - 9'h001);
	// Two ticks per divider period, so the master clock runs at the divider rate.
	assign div_tick = run_reg && (div_wrap || div_cnt_reg == {1'b0, half_period[8:1]} - 9'h001);
	// With the master clock on, the divider runs master clock; bit clock
	// then comes from a further 8 or 4 divide so that it stays 256 Fs. [RULE_10] [RULE_23]
	assign mck_ratio = frame32 ? 4'(MCLK_PER_BIT32) : 4'(MCLK_PER_BIT16);
	assign bit_tick = div_tick && (!master_clock_out_enable
		|| mck_cnt_reg == mck_ratio - 4'h1); // [RULE_08] [RULE_11]

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			div_cnt_reg <= 9'h000;
			mck_cnt_reg <= 4'h0;
			master_clock_out <= 1'b0;
		end else if (clk_en) begin
			if (!run_reg) begin
				div_cnt_reg <= 9'h000;
				mck_cnt_reg <= 4'h0;
				master_clock_out <= 1'b0;
			end else begin
				div_cnt_reg <= div_wrap ? 9'h000 : div_cnt_reg + 9'h001;
				if (div_tick) begin
					mck_cnt_reg <= (mck_cnt_reg == mck_ratio - 4'h1) ? 4'h0 : mck_cnt_reg + 4'h1;
					master_clock_out <= master_clock_out_enable && !master_clock_out; // [RULE_12]
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Frame sequencing
	// ------------------------------------------------------------
	// bit_phase 0 is the low bit-clock half (falling edge done, data set),
	// bit_phase 1 is the high half (rising edge, data sampled). [RULE_24]
	wire logic falling_now = bit_tick && bit_phase_reg;
	wire logic rising_now = bit_tick && !bit_phase_reg;
	wire logic last_bit = (bit_cnt_reg == 5'h0F);
	wire logic pcm = (audio_standard_sel == STD_PCM);
	wire logic lsb16in32 = (audio_standard_sel == STD_LSB) && frame32
		&& (sample_width_sel == SAMPLE_WIDTH_SEL_16);
	// Half-word 0 of a 32-bit channel is padding only in LSB 16-in-32. [RULE_03]
	wire logic pad_half = frame32 && ((lsb16in32 && half_cnt_reg[0] == 1'b0)
		|| (!lsb16in32 && sample_width_sel == SAMPLE_WIDTH_SEL_16 && half_cnt_reg[0]));
	wire logic [1:0] halves = frame32 ? 2'h3 : 2'h1;
	// Side of the slot after this one: left half-words come first. [RULE_15]
	wire logic next_right = (half_cnt_reg == halves) ? 1'b0 : (half_cnt_reg >= (frame32 ? 2'h1 : 2'h0));
	// Word select changes at channel boundaries; PCM uses a sync pulse. [RULE_05]
	wire logic [1:0] next_half = (half_cnt_reg == halves) ? 2'h0 : half_cnt_reg + 2'h1;
	wire logic [1:0] load_half = run_reg ? next_half : 2'h0;
	wire logic pad_load = frame32 && ((lsb16in32 && !load_half[0])
		|| (!lsb16in32 && sample_width_sel == SAMPLE_WIDTH_SEL_16 && load_half[0]));
	wire logic side_load = (load_half != halves) && (load_half >= (frame32 ? 2'h1 : 2'h0));
	wire logic stopping = last_bit && half_cnt_reg == halves && !audio_port_enable;
	wire logic start_now = !run_reg && audio_mode_select && audio_port_enable
		&& (rx_mode || busy_flag);
	wire logic [5:0] next_frame_bit = last_bit ? {next_half, 4'h0}
		: {half_cnt_reg, bit_cnt_reg[3:0] + 4'h1};
	assign sync_word = frame_sync_length_sel ? (next_frame_bit < 6'(LONG_SYNC_BITS))
		: (next_frame_bit == 6'h00);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			run_reg <= 1'b0;
			bit_phase_reg <= 1'b0;
			bit_cnt_reg <= 5'h00;
			half_cnt_reg <= 2'h0;
		end else if (clk_en) begin
			if (!run_reg) begin
				bit_phase_reg <= 1'b0;
				bit_cnt_reg <= 5'h00;
				half_cnt_reg <= 2'h0;
				// Start only with a port enabled and, in transmit, data waiting.
				run_reg <= start_now;
			end else if (falling_now) begin
				bit_phase_reg <= 1'b0;
				bit_cnt_reg <= last_bit ? 5'h00 : bit_cnt_reg + 5'h01;
				if (last_bit) begin
					half_cnt_reg <= (half_cnt_reg == halves) ? 2'h0 : half_cnt_reg + 2'h1;
					// Stop only at a frame end so a lone left channel never goes out. [RULE_15] [RULE_22]
					if (half_cnt_reg == halves && !audio_port_enable) begin
						run_reg <= 1'b0;
					end
				end
			end else if (rising_now) begin
				bit_phase_reg <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Pins
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bit_clock_out <= 1'b0;
			word_select_out <= 1'b0;
			serial_data_oe <= 1'b0;
			serial_data_out <= 1'b0;
		end else if (clk_en) begin
			// Bit clock and word select are always outputs here. [RULE_12] [RULE_25]
			// The clock follows the next phase, so it falls in the same cycle as data and select.
			bit_clock_out <= serial_clock_idle_level
				^ (run_reg && !falling_now && (rising_now || bit_phase_reg));
			serial_data_oe <= audio_mode_select && !rx_mode;
			if (!run_reg) begin
				word_select_out <= 1'b0;
				// The first MSB must already wait on the line before the first rising edge.
				serial_data_out <= start_now && !rx_mode && !pad_load && tx_buf_reg[15];
			end else if (falling_now && stopping) begin
				word_select_out <= 1'b0;
				serial_data_out <= 1'b0;
			end else if (falling_now) begin
				// Each falling edge presents the bit for the next rising edge. [RULE_16]
				serial_data_out <= last_bit ? (!pad_load && tx_buf_reg[15]) : shift_reg[15];
				if (pcm) begin
					// A sync only starts at frame bit 0, so a late start never gives a short sync.
					word_select_out <= sync_word && (next_frame_bit == 6'h00 || word_select_out); // [RULE_06]
				end else if (audio_standard_sel == STD_PHILIPS) begin
					word_select_out <= last_bit ? next_right : word_select_out;
				end else begin
					word_select_out <= ((last_bit ? next_half : half_cnt_reg)
						>= (frame32 ? 2'h2 : 2'h1)); // [RULE_01]
				end
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sd_in_meta_reg <= 1'b0;
			sd_in_reg <= 1'b0;
		end else if (clk_en) begin
			sd_in_meta_reg <= serial_data_in;
			sd_in_reg <= sd_in_meta_reg;
		end
	end

	// ------------------------------------------------------------
	// Shifter and buffers
	// ------------------------------------------------------------
	wire logic slot_start = run_reg && bit_tick && !bit_phase_reg && bit_cnt_reg == 5'h00;
	wire logic rx_word_done = run_reg && rx_mode && rising_now && last_bit && !pad_half;
	wire logic data_read = rd && addr == DATA_OFS;
	wire logic data_write = wr && addr == DATA_OFS;
	wire logic tx_load = !rx_mode && (start_now || (falling_now && last_bit && !stopping));

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_reg <= 16'h0000;
			tx_buf_reg <= 16'h0000;
			rx_buf_reg <= 16'h0000;
			tx_empty_flag <= 1'b1;
			rx_full_flag <= 1'b0;
			overrun_flag <= 1'b0;
			channel_side_flag <= 1'b0;
			busy_flag <= 1'b0;
		end else if (clk_en) begin
			if (data_write) begin
				tx_buf_reg <= wdata;
				tx_empty_flag <= 1'b0;
				busy_flag <= 1'b1;
			end
			if (!audio_port_enable && !run_reg) begin
				tx_empty_flag <= 1'b0;
			end else if (!run_reg && !data_write && !busy_flag) begin
				tx_empty_flag <= 1'b1;
			end
			if (tx_load) begin
				if (pad_load) begin
					shift_reg <= 16'h0000; // [RULE_03]
				end else begin
					// The MSB is already on the line, so the shifter keeps the rest. [RULE_04] [RULE_14]
					shift_reg <= {tx_buf_reg[14:0], 1'b0};
					tx_empty_flag <= 1'b1;
					channel_side_flag <= pcm ? 1'b0 : side_load; // [RULE_14]
				end
			end else if (falling_now && !rx_mode) begin
				shift_reg <= {shift_reg[14:0], 1'b0};
			end else if (rising_now && rx_mode) begin
				shift_reg <= {shift_reg[14:0], sd_in_reg}; // [RULE_24]
			end
			if (falling_now && last_bit && !data_write) begin
				busy_flag <= !tx_empty_flag && !rx_mode;
			end
			if (slot_start && rx_mode) begin
				busy_flag <= 1'b1;
			end
			if (rx_word_done) begin
				// Flag set wins over a read in the same cycle. [RULE_19]
				if (rx_full_flag && !data_read) begin
					overrun_flag <= 1'b1; // [RULE_21]
				end else begin
					rx_buf_reg <= {shift_reg[14:0], sd_in_reg};
					channel_side_flag <= pcm ? 1'b0 : word_select_out; // [RULE_20]
				end
				rx_full_flag <= 1'b1; // [RULE_04]
			end else if (data_read) begin
				rx_full_flag <= 1'b0;
			end
			if (rd && addr == STATUS_OFS && !rx_full_flag && !rx_word_done) begin
				overrun_flag <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			audio_config_reg <= CFG_RESET;
			audio_prescaler_reg <= PR_RESET;
		end else if (clk_en && wr) begin
			if (addr == CONFIG_OFS) begin
				audio_config_reg <= wdata;
			end
			if (addr == PRESCALER_OFS) begin
				audio_prescaler_reg <= {6'h00, wdata[9:0]};
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 16'h0000;
			irq_out <= 1'b0;
			tx_dma_req <= 1'b0;
			rx_dma_req <= 1'b0;
		end else if (clk_en) begin
			irq_out <= (tx_empty_irq_enable && tx_empty_flag && !rx_mode)
				|| (rx_full_irq_enable && rx_full_flag)
				|| (error_irq_enable && overrun_flag); // [RULE_16] [RULE_21]
			tx_dma_req <= tx_empty_flag && !rx_mode && audio_port_enable;
			rx_dma_req <= rx_full_flag;
			if (rd) begin
				unique case (addr)
					DATA_OFS: rdata <= rx_buf_reg; // [RULE_02]
					STATUS_OFS: rdata <= 16'h0000 | (16'(rx_full_flag) << ST_RX_FULL_FLAG_BIT)
						| (16'(tx_empty_flag) << ST_TXE_BIT)
						| (16'(channel_side_flag) << ST_CHANNEL_SIDE_FLAG_BIT)
						| (16'(overrun_flag) << ST_OVR_BIT)
						| (16'(busy_flag) << ST_BSY_BIT);
					CONFIG_OFS: rdata <= audio_config_reg;
					PRESCALER_OFS: rdata <= audio_prescaler_reg;
					default: rdata <= 16'h0000;
				endcase
			end else begin
				rdata <= 16'h0000;
			end
		end
	end

endmodule

// ---- audio_serial_pkg.sv ----
package audio_serial_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte addresses, one register every 4 bytes)
	// ------------------------------------------------------------
	localparam logic [3:0] DATA_OFS = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h4;
	localparam logic [3:0] CONFIG_OFS = 4'h8;
	localparam logic [3:0] PRESCALER_OFS = 4'hC;

	// ------------------------------------------------------------
	// Config register fields
	// ------------------------------------------------------------
	localparam int CFG_CHANNEL_WIDTH_SEL_BIT = 0;
	localparam int CFG_SAMPLE_WIDTH_SEL_LSB = 1;
	localparam int CFG_SERIAL_CLOCK_IDLE_LEVEL_BIT = 3;
	localparam int CFG_STD_LSB = 4;
	localparam int CFG_FRAME_SYNC_LENGTH_SEL_BIT = 7;
	localparam int CFG_DIR_RX_BIT = 8;
	localparam int CFG_EN_BIT = 10;
	localparam int CFG_MODE_BIT = 11;
	localparam int CFG_TX_EMPTY_IRQ_ENABLE_BIT = 12;
	localparam int CFG_RX_FULL_IRQ_ENABLE_BIT = 13;
	localparam int CFG_ERROR_IRQ_ENABLE_BIT = 14;
	localparam logic [15:0] CFG_RESET = 16'h0000;

	// ------------------------------------------------------------
	// Prescaler register fields
	// ------------------------------------------------------------
	localparam int PR_ODD_BIT = 8;
	localparam int PR_MASTER_CLOCK_OUT_ENABLE_BIT = 9;
	localparam logic [15:0] PR_RESET = 16'h0002;

	// ------------------------------------------------------------
	// Status register fields
	// ------------------------------------------------------------
	localparam int ST_RX_FULL_FLAG_BIT = 0;
	localparam int ST_TXE_BIT = 1;
	localparam int ST_CHANNEL_SIDE_FLAG_BIT = 2;
	localparam int ST_OVR_BIT = 6;
	localparam int ST_BSY_BIT = 7;

	// ------------------------------------------------------------
	// Standards and timing
	// ------------------------------------------------------------
	localparam logic [1:0] STD_PHILIPS = 2'h0;
	localparam logic [1:0] STD_MSB = 2'h1;
	localparam logic [1:0] STD_LSB = 2'h2;
	localparam logic [1:0] STD_PCM = 2'h3;
	localparam logic [1:0] SAMPLE_WIDTH_SEL_16 = 2'h0;
	localparam logic [1:0] SAMPLE_WIDTH_SEL_24 = 2'h1;
	localparam logic [1:0] SAMPLE_WIDTH_SEL_32 = 2'h2;
	localparam int LONG_SYNC_BITS = 13;
	localparam int MCLK_PER_FS = 256;
	localparam int MCLK_PER_BIT16 = 8;
	localparam int MCLK_PER_BIT32 = 4;

endpackage

// ---- audio_serial_master_port_sva.sv ----
`timescale 1ns/1ns
module audio_serial_master_port_sva
	import audio_serial_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	input wire logic bit_clock_out,
	input wire logic word_select_out,
	input wire logic serial_data_oe,
	input wire logic master_clock_out,
	input wire logic irq_out
);
	// ------------------------------------------------------------
	// Shadow of the software settings
	// ------------------------------------------------------------
	logic [15:0] cfg_reg;
	logic [9:0] pr_reg;
	logic seen_reg;
	logic [1:0] age_reg;
	logic [7:0] per_reg;
	logic [3:0] falls_reg;
	logic [2:0] ie;
	logic mck_en;
	logic [7:0] div_eff;
	logic [11:0] per_exp;
	assign ie = cfg_reg[14:12];
	assign mck_en = pr_reg[PR_MASTER_CLOCK_OUT_ENABLE_BIT];
	assign div_eff = (pr_reg[7:0] < 8'h02) ? 8'h02 : pr_reg[7:0];
	// Bit period in system clocks; the master clock option stretches it by its ratio.
	assign per_exp = ({3'h0, div_eff, 1'b0} + {11'h000, pr_reg[PR_ODD_BIT]})
		* (mck_en ? (cfg_reg[CFG_CHANNEL_WIDTH_SEL_BIT] ? 12'h004 : 12'h008) : 12'h001);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_reg <= CFG_RESET;
			pr_reg <= PR_RESET[9:0];
			seen_reg <= 1'b0;
			age_reg <= 2'h0;
		end else if (wr && addr == CONFIG_OFS) begin
			cfg_reg <= wdata;
			seen_reg <= 1'b1;
			age_reg <= 2'h0;
		end else begin
			if (wr && addr == PRESCALER_OFS) pr_reg <= wdata[9:0];
			if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
		end
	end
	// A long idle gap saturates the counter, so a restart is never measured as a period.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) per_reg <= 8'hFF;
		else if ($rose(bit_clock_out)) per_reg <= 8'h01;
		else if (per_reg != 8'hFF) per_reg <= per_reg + 8'h01;
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) falls_reg <= 4'h0;
		else if ($rose(word_select_out)) falls_reg <= 4'h0;
		else if (word_select_out && $fell(bit_clock_out)) falls_reg <= falls_reg + 4'h1;
	end
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	sequence s_no_read;
		!rd;
	endsequence
	chk_read_idle_zero: assert property (s_no_read |=> rdata == 16'h0000)
		else $error("read data not zero outside a read");
	chk_idle_after_reset: assert property (!seen_reg |-> !bit_clock_out && !word_select_out)
		else $error("serial outputs not idle before configuration");
	chk_data_enable_dir: assert property (age_reg == 2'h3 |->
		serial_data_oe == (cfg_reg[CFG_MODE_BIT] && !cfg_reg[CFG_DIR_RX_BIT]))
		else $error("data output enable does not follow direction");
	chk_mclk_gated_off: assert property (!mck_en && !$past(mck_en) |-> $stable(master_clock_out))
		else $error("master clock moves while disabled");
	chk_bit_period_exact: assert property ($rose(bit_clock_out) && per_reg < 8'hC8 |->
		{4'h0, per_reg} == per_exp)
		else $error("bit clock period wrong");
	chk_ws_on_fall: assert property ($changed(word_select_out) && !cfg_reg[CFG_SERIAL_CLOCK_IDLE_LEVEL_BIT] |->
		$fell(bit_clock_out))
		else $error("word select moved off the falling clock edge");
	chk_pcm_sync_len: assert property ($fell(word_select_out) && cfg_reg[CFG_STD_LSB +: 2] == STD_PCM
		|-> falls_reg == (cfg_reg[CFG_FRAME_SYNC_LENGTH_SEL_BIT] ? 4'hC : 4'h0))
		else $error("frame sync length wrong");
	chk_irq_masked_off: assert property (ie == 3'h0 && $past(ie) == 3'h0 |-> !irq_out)
		else $error("interrupt raised with all enables clear");
endmodule

// ---- audio_codec_model.sv ----
`timescale 1ns/1ns
module audio_codec_model (
	input wire logic bclk,
	input wire logic ws,
	input wire logic sdo,
	input wire logic [15:0] word,
	output logic sdi,
	output logic [15:0] got
);
	// ------------------------------------------------------------
	// Serial side of the converter
	// ------------------------------------------------------------
	logic [15:0] heard = 16'h0000;
	logic [3:0] idx = 4'hF;
	logic ws_last = 1'b0;
	// The first rising edge of a word comes before any falling edge, so the top bit
	// must already wait on the line while the clock stands.
	assign sdi = word[idx];
	always @(posedge bclk) heard <= {heard[14:0], sdo};
	always @(negedge bclk) idx <= idx - 4'h1;
	always @(negedge bclk) begin
		#1;
		if (ws !== ws_last) got <= heard;
		ws_last <= ws;
	end
	initial got = 16'h0000;
endmodule

// ---- audio_serial_master_port_tb.sv ----
`timescale 1ns/1ns
module audio_serial_master_port_tb;
	import audio_serial_pkg::*;
	typedef struct {logic do_wr; logic [3:0] a; logic [15:0] d; logic [15:0] exp;} row_s;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdata;
	logic bit_clock_out;
	logic word_select_out;
	logic serial_data_out;
	logic serial_data_in;
	logic master_clock_out;
	logic irq_out;
	logic tx_dma_req;
	logic rx_dma_req;
	logic [15:0] got;
	logic [15:0] v;
	logic [15:0] v1;
	logic mprev;
	int errors = 0;
	int num_checks = 0;
	int n;
	row_s rows [6] = '{'{1'b0, CONFIG_OFS, 16'h0000, CFG_RESET},
		'{1'b0, PRESCALER_OFS, 16'h0000, PR_RESET}, '{1'b0, STATUS_OFS, 16'h0000, 16'h0000},
		'{1'b0, DATA_OFS, 16'h0000, 16'h0000}, '{1'b1, 4'h2, 16'hFFFF, 16'h0000},
		'{1'b1, PRESCALER_OFS, 16'hFC08, 16'h0008}};
	always #5 clk = ~clk;
	audio_serial_master_port u_audio_serial_master_port (.clk(clk), .arst_n(arst_n),
		.clk_en(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.bit_clock_out(bit_clock_out), .word_select_out(word_select_out),
		.serial_data_out(serial_data_out), .serial_data_oe(), .serial_data_in(serial_data_in),
		.master_clock_out(master_clock_out), .irq_out(irq_out), .tx_dma_req(tx_dma_req),
		.rx_dma_req(rx_dma_req));
	audio_codec_model u_audio_codec_model (.bclk(bit_clock_out), .ws(word_select_out),
		.sdo(serial_data_out), .word(16'hC3A6), .sdi(serial_data_in), .got(got));
	// ------------------------------------------------------------
	// Bus and checking tasks
	// ------------------------------------------------------------
	task automatic end_of_test();
		$display("Checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stuck(input string what);
		errors++;
		$display("Error %s expected done seen timeout", what);
		end_of_test();
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic wait_status(input int b, input logic val);
		logic [15:0] s;
		int k;
		for (k = 0; k < 3000; k++) begin
			rd_reg(STATUS_OFS, s);
			if (s[b] === val) break;
		end
		if (k == 3000) stuck("status wait");
	endtask
	task automatic wait_ws(input logic val, output int c);
		for (c = 0; c < 5000 && word_select_out !== val; c++) begin
			@(posedge clk);
			#1;
		end
		if (c == 5000) stuck("word select wait");
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].do_wr) wr_reg(rows[i].a, rows[i].d);
			rd_reg(rows[i].a, v);
			check("register read", rows[i].exp, v);
		end
		$display("Test register table done");
		wr_reg(PRESCALER_OFS, 16'h0204);
		wr_reg(CONFIG_OFS, 16'h1820);
		wr_reg(CONFIG_OFS, 16'h1C20);
		wr_reg(DATA_OFS, 16'hB2C5);
		wait_status(ST_TXE_BIT, 1'b1);
		rd_reg(STATUS_OFS, v);
		check("side after left", 16'h0004, v & 16'h0004);
		check("tx irq", 16'h0001, {15'h0000, irq_out});
		check("tx dma", 16'h0001, {15'h0000, tx_dma_req});
		n = 0;
		mprev = master_clock_out;
		repeat (64) begin
			@(posedge clk);
			#1;
			if (master_clock_out !== mprev) n++;
			mprev = master_clock_out;
		end
		check("master clock edges", 16'h0010, 16'(n));
		wr_reg(DATA_OFS, 16'h4D39);
		wait_status(ST_TXE_BIT, 1'b1);
		rd_reg(STATUS_OFS, v);
		check("side after right", 16'h0000, v & 16'h0004);
		repeat (40) @(posedge clk);
		check("left word on line", 16'hB2C5, got);
		wr_reg(DATA_OFS, 16'h9E17);
		wait_status(ST_TXE_BIT, 1'b1);
		repeat (40) @(posedge clk);
		check("right word on line", 16'h4D39, got);
		wr_reg(DATA_OFS, 16'h61A8);
		wait_status(ST_TXE_BIT, 1'b1);
		wait_status(ST_BSY_BIT, 1'b0);
		wr_reg(CONFIG_OFS, 16'h1820);
		repeat (2400) @(posedge clk);
		$display("Test transmit done");
		wr_reg(PRESCALER_OFS, 16'h0008);
		wr_reg(CONFIG_OFS, 16'h4910);
		wr_reg(CONFIG_OFS, 16'h4D10);
		wait_status(ST_RX_FULL_FLAG_BIT, 1'b1);
		rd_reg(STATUS_OFS, v1);
		check("rx dma", 16'h0001, {15'h0000, rx_dma_req});
		rd_reg(DATA_OFS, v);
		check("rx word", 16'hC3A6, v);
		rd_reg(STATUS_OFS, v);
		check("rx flag cleared", 16'h0000, v & 16'h0001);
		wait_status(ST_RX_FULL_FLAG_BIT, 1'b1);
		rd_reg(STATUS_OFS, v);
		check("rx side toggles", ~v1 & 16'h0004, v & 16'h0004);
		wait_status(ST_OVR_BIT, 1'b1);
		check("overrun irq", 16'h0001, {15'h0000, irq_out});
		rd_reg(DATA_OFS, v);
		rd_reg(STATUS_OFS, v);
		wr_reg(CONFIG_OFS, 16'h4910);
		wait_status(ST_RX_FULL_FLAG_BIT, 1'b1);
		repeat (1200) @(posedge clk);
		$display("Test receive done");
		for (int s = 0; s < 2; s++) begin
			wr_reg(CONFIG_OFS, 16'h0830 | 16'(s << 7));
			wr_reg(CONFIG_OFS, 16'h0C30 | 16'(s << 7));
			wr_reg(DATA_OFS, 16'h5AF0);
			wait_ws(1'b1, n);
			wait_ws(1'b0, n);
			check("sync length", s ? 16'(LONG_SYNC_BITS * 16) : 16'h0010, 16'(n));
			wr_reg(CONFIG_OFS, 16'h0830);
			repeat (1200) @(posedge clk);
		end
		$display("Test frame sync done");
		end_of_test();
	end
endmodule
bind audio_serial_master_port audio_serial_master_port_sva u_audio_serial_master_port_sva (
	.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.bit_clock_out(bit_clock_out), .word_select_out(word_select_out),
	.serial_data_oe(serial_data_oe), .master_clock_out(master_clock_out), .irq_out(irq_out));
